// ===== pmcs_power_mode_clock_switch.sv
// power mode and clock source switch with apb control registers
// assumes oscillator pins and level status pins are asynchronous, apb and cpu on clk
`timescale 1ns/1ps
`include "pmcs_cfg.svh"

// Functional notes
// RL1 - select 00 primary, 01 secondary, 1x internal
// RL2 - primary type comes from configuration field
// RL3 - select write starts switch when source runs
// RL4 - halt: idle bit picks sleep or idle
// RL5 - run modes clock cpu and peripherals alike
// RL6 - each halt uses idle bit current value
// RL7 - switch: two old plus three-four new
// RL8 - primary active bit while primary clocks device
// RL9 - fast stable bit while fast osc drives
// RL10 - secondary active bit while timer1 clocks device
// RL11 - status clear on slow or unstable fast
// RL12 - internal primary may show both status bits
// RL13 - internal mode entry clears primary active bit
// RL14 - reset enters primary run, primary active set
// RL15 - select 01: timer1 clock, primary off, bits
// RL16 - secondary disabled: select 01 is ignored
// RL17 - timer1 not yet running: hold device clocks
// RL18 - stay on timer1 until primary is ready
// RL19 - switch leaves controls and timer1 untouched
// RL20 - software starts timer1 before selecting it
// RL21 - crystal primary waits 1024 oscillator cycles
// RL22 - halt is one pulse, idle bit sampled then
module pmcs_power_mode_clock_switch #(
	parameter int unsigned OST_CYCLES = `PMCS_OST_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration strap
	input wire logic [3:0] primary_osc_config,
	// oscillator pins and analog status
	input wire logic [`PMCS_OSC_NUM-1:0] osc_in,
	input wire logic sec_osc_running,
	input wire logic fast_osc_stable,
	// cpu core
	input wire logic halt_pulse,
	input wire logic wake_pulse,
	// clock enables and oscillator controls
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic pri_osc_enable,
	output logic sec_osc_enable_out,
	output pmcs_pkg::pmcs_src_e active_source,
	output pmcs_pkg::pmcs_state_e pm_state
);
	import pmcs_pkg::*;

	localparam int unsigned SU_W = $clog2(OST_CYCLES + 1);
	// the counter starts at zero, so the last count equals the full tick count
	localparam logic [SU_W-1:0] SU_LAST = SU_W'(OST_CYCLES);
	localparam logic [1:0] OLD_LAST = 2'(`PMCS_OLD_CYCLES - 1);
	localparam logic [1:0] NEW_LAST = 2'(`PMCS_NEW_CYCLES - 1);

	logic idle_on_halt_reg;
	logic [2:0] internal_freq_select_reg;
	logic [1:0] clock_select_reg;
	logic secondary_osc_enable_reg;
	logic primary_clock_active_reg;
	logic fast_internal_stable_reg;
	logic secondary_clock_active_reg;
	pmcs_state_e state_reg;
	pmcs_state_e state_next;
	pmcs_src_e cur_reg;
	pmcs_src_e tgt_reg;
	logic [1:0] sw_cnt_reg;
	logic [1:0] sw_cnt_next;
	logic [SU_W-1:0] su_cnt_reg;
	logic [6:0] div_cnt_reg;
	logic [3:0] cfg_s1_reg;
	logic [3:0] cfg_reg;
	logic cfg_arm_reg;
	logic cfg_taken_reg;
	logic [1:0] lvl_s1_reg;
	logic [1:0] lvl_s2_reg;
	logic [`PMCS_OSC_NUM-1:0] osc_tick;

	// oscillator edge ticks, one synchroniser each
	genvar gi;
	generate
		for (gi = 0; gi < `PMCS_OSC_NUM; gi++) begin : g_tick
			pmcs_osc_tick u_tick (
				.clk(clk),
				.rst(rst),
				.osc_in(osc_in[gi]),
				.tick(osc_tick[gi])
			);
		end
	endgenerate

	wire secondary_run_s = lvl_s2_reg[0];
	wire fast_stable_s = lvl_s2_reg[1];

	// primary type from the configuration strap
	wire cfg_internal = (cfg_reg == `PMCS_CFG_INT_A) || (cfg_reg == `PMCS_CFG_INT_B); // RL2
	wire cfg_crystal = (cfg_reg <= `PMCS_CFG_XTAL_MAX) || (cfg_reg == `PMCS_CFG_HSPLL); // RL2

	// internal block: slow osc direct, else fast osc through the postscaler
	wire [6:0] post_mask = `PMCS_POST_MASK >> internal_freq_select_reg;
	wire int_slow = internal_freq_select_reg == `PMCS_IFS_SLOW;
	wire fast_div_hit = osc_tick[`PMCS_OSC_FAST] && ((div_cnt_reg & post_mask) == post_mask);
	wire int_tick = int_slow ? osc_tick[`PMCS_OSC_SLOW] : fast_div_hit;
	wire pri_tick = cfg_internal ? int_tick : osc_tick[`PMCS_OSC_PRI]; // RL2

	// source select decode, low bit ignored when high bit set
	wire pmcs_src_e sel_src = clock_select_reg[`PMCS_CS_HI] ? PMCS_SRC_INT :
		(clock_select_reg[`PMCS_CS_LO] ? PMCS_SRC_SEC : PMCS_SRC_PRI); // RL1

	// readiness of each source
	wire su_done = su_cnt_reg == SU_LAST;
	wire pri_ready = pri_osc_enable && (!cfg_crystal || su_done); // RL21
	wire sec_ready = secondary_osc_enable_reg && secondary_run_s; // RL17

	function automatic logic src_pick(input pmcs_src_e s, input logic p, input logic q,
		input logic r);
		src_pick = (s == PMCS_SRC_PRI) ? p : ((s == PMCS_SRC_SEC) ? q : r);
	endfunction : src_pick

	wire cur_tick = src_pick(cur_reg, pri_tick, osc_tick[`PMCS_OSC_SEC], int_tick);
	wire tgt_tick = src_pick(tgt_reg, pri_tick, osc_tick[`PMCS_OSC_SEC], int_tick);
	wire cur_ready = src_pick(cur_reg, pri_ready, sec_ready, 1'b1);
	wire sel_ready = src_pick(sel_src, pri_ready, sec_ready, 1'b1);

	// switch request, blocked when secondary is not enabled
	wire sel_blocked = (sel_src == PMCS_SRC_SEC) && !secondary_osc_enable_reg; // RL16
	wire want_switch = (sel_src != cur_reg) && !sel_blocked; // RL3
	wire awake = (state_reg == PMCS_ST_RUN) || (state_reg == PMCS_ST_WAIT);
	wire halt_take = halt_pulse && awake; // RL22
	wire in_switch = (state_reg == PMCS_ST_SW_OLD) || (state_reg == PMCS_ST_SW_NEW);
	wire live = state_reg != PMCS_ST_SLEEP;

	// mode sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PMCS_ST_RUN, PMCS_ST_WAIT: begin
				if (halt_take) begin
					state_next = idle_on_halt_reg ? PMCS_ST_IDLE : PMCS_ST_SLEEP; // RL4 RL6
				end else if (!want_switch) begin
					state_next = PMCS_ST_RUN;
				end else if (sel_ready) begin
					state_next = PMCS_ST_SW_OLD; // RL3
				end else begin
					state_next = PMCS_ST_WAIT; // RL17 RL18
				end
			end
			PMCS_ST_SW_OLD: begin
				if (cur_tick && sw_cnt_reg == OLD_LAST) begin
					state_next = PMCS_ST_SW_NEW; // RL7
				end
			end
			PMCS_ST_SW_NEW: begin
				if (tgt_tick && sw_cnt_reg == NEW_LAST) begin
					state_next = PMCS_ST_RUN; // RL7
				end
			end
			PMCS_ST_IDLE, PMCS_ST_SLEEP: begin
				if (wake_pulse) begin
					state_next = PMCS_ST_RUN;
				end
			end
			default: begin
				state_next = PMCS_ST_RUN;
			end
		endcase
	end

	// transition counter counts old ticks, then new ticks
	wire count_tick = ((state_reg == PMCS_ST_SW_OLD) && cur_tick) ||
		((state_reg == PMCS_ST_SW_NEW) && tgt_tick);
	always_comb begin
		sw_cnt_next = sw_cnt_reg;
		if (state_next != state_reg) begin
			sw_cnt_next = 2'h0;
		end else if (count_tick) begin
			sw_cnt_next = sw_cnt_reg + 2'h1; // RL7
		end
	end

	// clock enables: all held during the switch itself for a glitch-free handover
	wire run_clk = (state_reg == PMCS_ST_RUN) && cur_ready && cur_tick; // RL5
	wire wait_clk = (state_reg == PMCS_ST_WAIT) && (sel_src != PMCS_SRC_SEC) && cur_tick; // RL18
	wire cpu_next = run_clk || wait_clk; // RL4
	wire idle_clk = (state_reg == PMCS_ST_IDLE) && cur_ready && cur_tick; // RL4
	wire periph_next = cpu_next || idle_clk; // RL5

	// primary runs while used or wanted; off in sleep and after leaving it
	wire pri_en_next = (live && cur_reg == PMCS_SRC_PRI) ||
		((awake || in_switch) && tgt_reg == PMCS_SRC_PRI); // RL15

	// status bits
	wire pri_act_next = live && cur_reg == PMCS_SRC_PRI && pri_ready; // RL8 RL13 RL14
	wire fast_src = (cur_reg == PMCS_SRC_INT) || (cur_reg == PMCS_SRC_PRI && cfg_internal); // RL12
	wire fast_stb_next = live && fast_stable_s && !int_slow && fast_src; // RL9 RL11
	wire sec_act_next = live && cur_reg == PMCS_SRC_SEC; // RL10 RL15

	// apb decode: answer one cycle into the access phase
	wire apb_acc = psel && penable && !pready;
	wire apb_done = psel && penable && pready;
	wire hit_osc = paddr == `PMCS_ADDR_OSC_CTRL;
	wire hit_t1 = paddr == `PMCS_ADDR_T1_CTRL;
	wire hit_st = paddr == `PMCS_ADDR_STATUS;
	wire hit_any = hit_osc || hit_t1 || hit_st;
	wire wr_osc = apb_done && pwrite && hit_osc;
	wire wr_t1 = apb_done && pwrite && hit_t1;
	wire [31:0] rd_osc = {24'h0, idle_on_halt_reg, internal_freq_select_reg,
		primary_clock_active_reg, fast_internal_stable_reg, clock_select_reg};
	wire [31:0] rd_t1 = {24'h0, 1'b0, secondary_clock_active_reg, 2'h0,
		secondary_osc_enable_reg, 3'h0};
	wire [31:0] rd_st = {20'h0, cfg_reg, 1'b0, pri_ready, cur_reg, 1'b0, state_reg};
	wire [31:0] rd_mux = hit_osc ? rd_osc : (hit_t1 ? rd_t1 : (hit_st ? rd_st : 32'h0));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc && !hit_any;
			prdata <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// software controls change only by apb, never by the sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_on_halt_reg <= `PMCS_IDLE_RST;
			internal_freq_select_reg <= `PMCS_IFS_RST;
			clock_select_reg <= `PMCS_CS_RST;
			secondary_osc_enable_reg <= `PMCS_SEC_EN_RST;
		end else begin
			if (wr_osc) begin
				idle_on_halt_reg <= pwdata[`PMCS_IDLE_BIT]; // RL19
				internal_freq_select_reg <= pwdata[`PMCS_IFS_HI:`PMCS_IFS_LO];
				clock_select_reg <= pwdata[`PMCS_CS_HI:`PMCS_CS_LO]; // RL19
			end
			if (wr_t1) begin
				secondary_osc_enable_reg <= pwdata[`PMCS_SEC_EN_BIT]; // RL19
			end
		end
	end

	// strap taken through two flops after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_s1_reg <= `PMCS_CFG_RST;
			cfg_reg <= `PMCS_CFG_RST;
			cfg_arm_reg <= 1'b0;
			cfg_taken_reg <= 1'b0;
		end else begin
			cfg_s1_reg <= primary_osc_config;
			cfg_arm_reg <= 1'b1;
			if (cfg_arm_reg && !cfg_taken_reg) begin
				cfg_reg <= cfg_s1_reg; // RL2
				cfg_taken_reg <= 1'b1;
			end
		end
	end

	// level status pins synchronised
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_s1_reg <= 2'h0;
			lvl_s2_reg <= 2'h0;
		end else begin
			lvl_s1_reg <= {fast_osc_stable, sec_osc_running};
			lvl_s2_reg <= lvl_s1_reg;
		end
	end

	// start-up counter; reset shows it expired so the device starts in primary run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			su_cnt_reg <= SU_LAST;
			div_cnt_reg <= 7'h00;
		end else begin
			if (!pri_osc_enable) begin
				su_cnt_reg <= '0; // RL21
			end else if (!su_done && osc_tick[`PMCS_OSC_PRI]) begin
				su_cnt_reg <= su_cnt_reg + SU_W'(1); // RL21
			end
			if (osc_tick[`PMCS_OSC_FAST]) begin
				div_cnt_reg <= div_cnt_reg + 7'h01;
			end
		end
	end

	// sequencer state and sources
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= PMCS_ST_RUN; // RL14
			cur_reg <= PMCS_SRC_PRI; // RL14
			tgt_reg <= PMCS_SRC_PRI;
			sw_cnt_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			sw_cnt_reg <= sw_cnt_next;
			if (awake) begin
				tgt_reg <= sel_src;
			end
			if (state_reg == PMCS_ST_SW_NEW && state_next == PMCS_ST_RUN) begin
				cur_reg <= tgt_reg; // RL15 RL18
			end
		end
	end

	// registered outputs and status
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			pri_osc_enable <= 1'b1;
			primary_clock_active_reg <= 1'b1; // RL14
			fast_internal_stable_reg <= 1'b0;
			secondary_clock_active_reg <= 1'b0;
		end else begin
			cpu_clk_en <= cpu_next;
			periph_clk_en <= periph_next;
			pri_osc_enable <= pri_en_next;
			primary_clock_active_reg <= pri_act_next;
			fast_internal_stable_reg <= fast_stb_next;
			secondary_clock_active_reg <= sec_act_next;
		end
	end

	// timer1 keeps running whatever the switch does
	assign sec_osc_enable_out = secondary_osc_enable_reg; // RL19
	assign active_source = cur_reg;
	assign pm_state = state_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	AST_DECODE_INT: assert property ( // RL1
		(state_reg == PMCS_ST_RUN && clock_select_reg[`PMCS_CS_HI] && want_switch && sel_ready)
		|=> state_reg == PMCS_ST_SW_OLD && tgt_reg == PMCS_SRC_INT)
		else $error("internal select did not start a switch");
	AST_SLEEP_OFF: assert property ( // RL4
		state_reg == PMCS_ST_SLEEP |=> !cpu_clk_en && !periph_clk_en && !pri_osc_enable)
		else $error("clock left running in sleep");
	AST_IDLE_CPU: assert property ( // RL4
		state_reg == PMCS_ST_IDLE && cur_ready && cur_tick |=> !cpu_clk_en && periph_clk_en)
		else $error("idle clocking wrong");
	AST_HALT_SAMPLE: assert property ( // RL6
		halt_pulse && state_reg == PMCS_ST_RUN
		|=> state_reg == ($past(idle_on_halt_reg) ? PMCS_ST_IDLE : PMCS_ST_SLEEP))
		else $error("halt entered wrong mode");
	AST_RUN_CLOCKS: assert property ( // RL5
		state_reg == PMCS_ST_RUN && cur_ready && cur_tick |=> cpu_clk_en && periph_clk_en)
		else $error("run mode tick dropped");
	AST_OLD_TWO: assert property ( // RL7
		state_reg == PMCS_ST_SW_OLD ##1 state_reg == PMCS_ST_SW_NEW
		|-> $past(sw_cnt_reg) == 2'h1 && $past(cur_tick))
		else $error("old clock phase not two cycles");
	AST_NEW_THREE: assert property ( // RL7
		state_reg == PMCS_ST_SW_NEW ##1 state_reg == PMCS_ST_RUN
		|-> $past(sw_cnt_reg) == 2'h2 && $past(tgt_tick))
		else $error("new clock phase not three cycles");
	AST_PRI_ACTIVE: assert property ( // RL8
		state_reg == PMCS_ST_RUN && cur_reg == PMCS_SRC_PRI && pri_ready
		|=> primary_clock_active_reg && !secondary_clock_active_reg)
		else $error("primary active bit missing");
	AST_SEC_ACTIVE: assert property ( // RL15
		cur_reg == PMCS_SRC_SEC && live
		|=> secondary_clock_active_reg && !primary_clock_active_reg)
		else $error("secondary status wrong");
	AST_SLOW_CLEAR: assert property ( // RL11
		cur_reg == PMCS_SRC_INT && int_slow
		|=> !fast_internal_stable_reg && !primary_clock_active_reg && !secondary_clock_active_reg)
		else $error("status set on slow internal osc");
	AST_SEC_BLOCKED: assert property ( // RL16
		state_reg == PMCS_ST_RUN && sel_blocked && !halt_pulse |=> state_reg == PMCS_ST_RUN)
		else $error("disabled secondary was entered");
	AST_SEC_HOLD: assert property ( // RL17
		state_reg == PMCS_ST_WAIT && sel_src == PMCS_SRC_SEC |=> !cpu_clk_en)
		else $error("clocks not held for unstarted timer1");
	AST_OST_COUNT: assert property ( // RL21
		$rose(su_done) |-> $past(su_cnt_reg) == SU_LAST - SU_W'(1) && $past(pri_osc_enable))
		else $error("start-up count skipped");
	AST_CTRL_KEEP: assert property ( // RL19
		!wr_osc |=> $stable(clock_select_reg) && $stable(idle_on_halt_reg))
		else $error("controls changed without a write");

	COV_SECONDARY_RUN: cover property (state_reg == PMCS_ST_SW_NEW ##1 cur_reg == PMCS_SRC_SEC);
	COV_BACK_PRI: cover property (cur_reg == PMCS_SRC_SEC ##[1:1000] cur_reg == PMCS_SRC_PRI);
	COV_IDLE: cover property (state_reg == PMCS_ST_IDLE && periph_clk_en);
	COV_SLEEP: cover property (state_reg == PMCS_ST_SLEEP);
endmodule : pmcs_power_mode_clock_switch

// ===== pmcs_cfg.svh
// named offsets, field positions, reset values and counts of the clock switch
// assumes inclusion by the switch module and the bench top only
`ifndef PMCS_CFG_SVH
`define PMCS_CFG_SVH

// apb register byte addresses
`define PMCS_ADDR_OSC_CTRL 12'h000
`define PMCS_ADDR_T1_CTRL 12'h004
`define PMCS_ADDR_STATUS 12'h008

// oscillator control field positions
`define PMCS_IDLE_BIT 7
`define PMCS_IFS_HI 6
`define PMCS_IFS_LO 4
`define PMCS_CS_HI 1
`define PMCS_CS_LO 0
// timer1 control field positions
`define PMCS_SEC_EN_BIT 3

// reset values
`define PMCS_IDLE_RST 1'h0
`define PMCS_IFS_RST 3'h4
`define PMCS_CS_RST 2'h0
`define PMCS_SEC_EN_RST 1'h0
`define PMCS_CFG_RST 4'h0

// internal oscillator frequency codes
`define PMCS_IFS_SLOW 3'h0
`define PMCS_POST_MASK 7'h7F

// primary oscillator configuration codes
`define PMCS_CFG_XTAL_MAX 4'h2
`define PMCS_CFG_HSPLL 4'h6
`define PMCS_CFG_INT_A 4'h8
`define PMCS_CFG_INT_B 4'h9

// oscillator pin indices
`define PMCS_OSC_PRI 0
`define PMCS_OSC_SEC 1
`define PMCS_OSC_FAST 2
`define PMCS_OSC_SLOW 3
`define PMCS_OSC_NUM 4

// oscillator cycle counts
`define PMCS_OST_CYCLES 1024
`define PMCS_OLD_CYCLES 2
`define PMCS_NEW_CYCLES 3

`endif

// ===== pmcs_pkg.sv
// types shared by the power mode clock switch
// assumes the cfg header is on the include path
package pmcs_pkg;
	typedef enum logic [2:0] {
		PMCS_ST_RUN = 3'h0,
		PMCS_ST_WAIT = 3'h1,
		PMCS_ST_SW_OLD = 3'h3,
		PMCS_ST_SW_NEW = 3'h2,
		PMCS_ST_IDLE = 3'h6,
		PMCS_ST_SLEEP = 3'h7
	} pmcs_state_e;

	typedef enum logic [1:0] {
		PMCS_SRC_PRI = 2'h0,
		PMCS_SRC_SEC = 2'h1,
		PMCS_SRC_INT = 2'h2
	} pmcs_src_e;
endpackage : pmcs_pkg

// ===== pmcs_osc_tick.sv
// one oscillator pin turned into a one-cycle tick per rising edge
// assumes the oscillator runs well below half of clk
`timescale 1ns/1ps
module pmcs_osc_tick (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// oscillator pin
	input wire logic osc_in,
	// tick on clk
	output logic tick
);
	logic s1_reg;
	logic s2_reg;
	logic prev_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			prev_reg <= 1'b0;
			tick <= 1'b0;
		end else begin
			s1_reg <= osc_in;
			s2_reg <= s1_reg;
			prev_reg <= s2_reg;
			tick <= s2_reg & ~prev_reg;
		end
	end
endmodule : pmcs_osc_tick

// ===== pmcs_osc_model.sv
// oscillator pins and timer1 start-up as the clock switch sees them
// assumes the enables come from the switch; pins run on their own time base
`timescale 1ns/1ps
module pmcs_osc_model (
	// oscillator controls
	input wire logic pri_en,
	input wire logic sec_en,
	// pins and timer1 status
	output logic [3:0] osc,
	output logic sec_running
);
	int sec_edges;
	initial begin
		osc = 4'h0;
		sec_edges = 0;
		sec_running = 1'h0;
	end
	// a stopped pin rests low, as a disabled oscillator would
	always #21 osc[0] = pri_en ? ~osc[0] : 1'h0;
	// timer1 reports running only after a start-up span, never at once
	always #31 begin
		osc[1] = sec_en ? ~osc[1] : 1'h0;
		sec_edges = sec_en ? sec_edges + 1 : 0;
		sec_running = (sec_edges > 16);
	end
	always #16 osc[2] = ~osc[2];
	always #27 osc[3] = ~osc[3];
endmodule : pmcs_osc_model

// ===== pmcs_power_mode_clock_switch_tb_top.sv
// self-checking bench of the power mode clock switch
// assumes the oscillator model file and the design files are compiled first
`timescale 1ns/1ps
`include "pmcs_cfg.svh"
module pmcs_power_mode_clock_switch_tb_top;
	import pmcs_pkg::*;
	// switch length bounds follow the model periods, 42 ns old and 62 ns new
	localparam int SW_LO = 33;
	localparam int SW_HI = 64;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] strap, osc;
	logic secondary_run, fast_stable, halt_pulse, wake_pulse;
	logic cpu_clk_en, periph_clk_en, pri_osc_enable, sec_osc_enable_out;
	pmcs_src_e active_source;
	pmcs_state_e pm_state;
	int failures, cmp_count;

	pmcs_power_mode_clock_switch #(.OST_CYCLES(4)) dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .primary_osc_config(strap), .osc_in(osc),
		.sec_osc_running(secondary_run), .fast_osc_stable(fast_stable), .halt_pulse(halt_pulse),
		.wake_pulse(wake_pulse), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.pri_osc_enable(pri_osc_enable), .sec_osc_enable_out(sec_osc_enable_out),
		.active_source(active_source), .pm_state(pm_state));
	pmcs_osc_model osc_model (.pri_en(pri_osc_enable), .sec_en(sec_osc_enable_out),
		.osc(osc), .sec_running(secondary_run));

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	function automatic logic [31:0] osc_exp(input logic i, input logic [2:0] f,
		input logic pa, input logic fs, input logic [1:0] cs);
		return {24'h0, i, f, pa, fs, cs};
	endfunction : osc_exp

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1) begin
			failures++;
			$display("Error apb_pready expected 1 seen %h", pready);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task rdc(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk("prdata", r, x);
	endtask : rdc

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask : wr

	// bounded wait; counts a failure itself if the state is not reached
	task wait_st(input pmcs_state_e s, input int lim, output int n);
		n = 0;
		while (pm_state !== s && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (pm_state !== s) begin
			failures++;
			$display("Error pm_state_wait expected %0d seen %0d", s, pm_state);
		end
	endtask : wait_st

	task cnt(input int n, output int c, output int p);
		c = 0;
		p = 0;
		repeat (n) begin
			@(posedge clk);
			c += (cpu_clk_en === 1'h1);
			p += (periph_clk_en === 1'h1);
		end
	endtask : cnt

	task pulse(input logic h);
		@(posedge clk);
		if (h) halt_pulse <= 1'h1;
		else wake_pulse <= 1'h1;
		@(posedge clk);
		halt_pulse <= 1'h0;
		wake_pulse <= 1'h0;
	endtask : pulse

	initial begin
		#200000;
		failures++;
		end_of_test;
	end

	initial begin
		logic [31:0] r;
		logic e, idl;
		logic [2:0] f;
		logic [1:0] cs;
		logic [11:0] ua;
		int n, c, p;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{halt_pulse, wake_pulse, fast_stable, strap} = '0;
		rst = 1'h1;
		failures = 0;
		cmp_count = 0;
		void'($urandom(39899));
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (3) @(posedge clk);
		chk("pri_osc_enable", pri_osc_enable, 1);
		chk("active_source", active_source, PMCS_SRC_PRI);
		rdc(`PMCS_ADDR_OSC_CTRL, osc_exp(1'h0, 3'h4, 1'h1, 1'h0, 2'h0));
		rdc(`PMCS_ADDR_T1_CTRL, 32'h0);
		ua = 12'h00C + 12'(4 * ($urandom % 1000));
		apb(1'h1, ua, $urandom, r, e);
		chk("pslverr", e, 1);
		cnt(60, c, p);
		chk("run_clocks", c == p && c > 0, 1);
		// timer1 still disabled, so the select must be refused
		wr(`PMCS_ADDR_OSC_CTRL, 32'h41);
		repeat (30) @(posedge clk);
		chk("pm_state", pm_state, PMCS_ST_RUN);
		chk("active_source", active_source, PMCS_SRC_PRI);
		wr(`PMCS_ADDR_OSC_CTRL, 32'h40);
		wr(`PMCS_ADDR_T1_CTRL, 32'h08);
		wr(`PMCS_ADDR_OSC_CTRL, 32'h41);
		wait_st(PMCS_ST_WAIT, 10, n);
		chk("pm_state", pm_state, PMCS_ST_WAIT);
		cnt(20, c, p);
		chk("held_cpu_clocks", c, 0);
		wait_st(PMCS_ST_SW_OLD, 400, n);
		wait_st(PMCS_ST_RUN, 200, n);
		chk("switch_len", n >= SW_LO && n <= SW_HI, 1);
		chk("active_source", active_source, PMCS_SRC_SEC);
		// the enable is registered from the new source one edge after it shows
		rdc(`PMCS_ADDR_T1_CTRL, 32'h48);
		rdc(`PMCS_ADDR_OSC_CTRL, osc_exp(1'h0, 3'h4, 1'h0, 1'h0, 2'h1));
		chk("pri_osc_enable", pri_osc_enable, 0);
		wr(`PMCS_ADDR_OSC_CTRL, 32'h40);
		wait_st(PMCS_ST_WAIT, 10, n);
		cnt(14, c, p);
		chk("clocks_while_waiting", c > 0, 1);
		// still counting start-up ticks: waiting, on timer1, primary not ready
		rdc(`PMCS_ADDR_STATUS, 32'h011);
		wait_st(PMCS_ST_RUN, 600, n);
		chk("active_source", active_source, PMCS_SRC_PRI);
		rdc(`PMCS_ADDR_T1_CTRL, 32'h08);
		chk("sec_osc_enable_out", sec_osc_enable_out, 1);
		fast_stable <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			f = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom_range(7, 1));
			cs = (i == 2) ? 2'h3 : 2'h2;
			wr(`PMCS_ADDR_OSC_CTRL, 32'({1'h0, f, 2'h0, cs}));
			wait_st(PMCS_ST_SW_OLD, 20, n);
			chk("pm_state", pm_state, PMCS_ST_SW_OLD);
			// the slowest postscaler code gives about 410 cycles per tick
			wait_st(PMCS_ST_RUN, 1400, n);
			chk("active_source", active_source, PMCS_SRC_INT);
			rdc(`PMCS_ADDR_OSC_CTRL, osc_exp(1'h0, f, 1'h0, f != 3'h0, cs));
			wr(`PMCS_ADDR_OSC_CTRL, 32'h40);
			repeat (3) @(posedge clk);
			wait_st(PMCS_ST_RUN, 600, n);
		end
		// the idle bit flips between the first two halts; random draws follow the fixed pair
		for (int i = 0; i < 4; i++) begin
			idl = (i < 2) ? (i == 0) : 1'($urandom % 2);
			wr(`PMCS_ADDR_OSC_CTRL, {24'h0, idl, 7'h40});
			pulse(1'h1);
			wait_st(idl ? PMCS_ST_IDLE : PMCS_ST_SLEEP, 4, n);
			chk("pm_state", pm_state, idl ? PMCS_ST_IDLE : PMCS_ST_SLEEP);
			cnt(60, c, p);
			chk("cpu_en", c, 0);
			chk("periph_en", p > 0, idl);
			if (!idl) chk("pri_osc_enable", pri_osc_enable, 0);
			pulse(1'h0);
			wait_st(PMCS_ST_RUN, 600, n);
		end
		// second reset in mid-run, internal block strapped as primary
		rst <= 1'h1;
		strap <= 4'h8;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		repeat (5) @(posedge clk);
		rdc(`PMCS_ADDR_STATUS, 32'h840);
		rdc(`PMCS_ADDR_OSC_CTRL, osc_exp(1'h0, 3'h4, 1'h1, 1'h1, 2'h0));
		wr(`PMCS_ADDR_OSC_CTRL, 32'h42);
		repeat (3) @(posedge clk);
		wait_st(PMCS_ST_RUN, 400, n);
		rdc(`PMCS_ADDR_OSC_CTRL, osc_exp(1'h0, 3'h4, 1'h0, 1'h1, 2'h2));
		end_of_test;
	end
endmodule : pmcs_power_mode_clock_switch_tb_top
